/* vacr_cfg.svh */
// offsets, field positions, reset values and timing counts for the config bank
`ifndef VACR_CFG_SVH
`define VACR_CFG_SVH
`define VACR_ADDR_ERR_TALLY 8'h25
`define VACR_ADDR_HIGH_SPAN 8'h26
`define VACR_ADDR_LOW_SPAN 8'h27
`define VACR_ADDR_PATH_CTL2 8'h28
`define VACR_ADDR_DITHER_CTL 8'h29
`define VACR_ADDR_BALANCE_CTL 8'h2a
`define VACR_ADDR_AUDIO_CTL 8'h2b
`define VACR_RST_ERR_TALLY 8'h00
`define VACR_RST_HIGH_SPAN 8'h83
`define VACR_RST_LOW_SPAN 8'h84
`define VACR_RST_ZERO 8'h00
`define VACR_MASK_PATH_CTL2 8'h8d
`define VACR_MASK_BALANCE_CTL 8'hf0
`define VACR_MASK_AUDIO_CTL 8'hc1
`define VACR_TALLY_MAX 8'hff
`define VACR_BIT_FC_BLOCK 7
`define VACR_BIT_AUX_AUDIO 3
`define VACR_BIT_AUDIO_OFF 2
`define VACR_BIT_SURROUND 0
`define VACR_BIT_SYNC_MODE 7
`define VACR_BIT_LSYNC_POL 6
`define VACR_BIT_FSYNC_POL 5
`define VACR_BIT_PVALID_POL 4
`define VACR_BIT_DITH_TWO 3
`define VACR_BIT_DITH_ONE 2
`define VACR_BIT_FINE_TWO 1
`define VACR_BIT_FINE_ONE 0
`define VACR_BIT_BAL_EN 5
`define VACR_BIT_LUT_RELOAD 4
`define VACR_BIT_PLL_OVR 7
`define VACR_BIT_PLL_OFF 6
`define VACR_BIT_EDGE_RISE 0
`define VACR_SPAN_UNIT_NS 50
`define VACR_CLK_NS 25
`define VACR_CYC_PER_UNIT ((`VACR_SPAN_UNIT_NS + `VACR_CLK_NS - 1) / `VACR_CLK_NS)
`endif

/* vacr_pkg.sv */
// types shared by the config bank
package vacr_pkg;
    typedef enum logic [1:0] {
        VACR_PAGE_CFG,
        VACR_PAGE_RED,
        VACR_PAGE_GREEN,
        VACR_PAGE_BLUE
    } vacr_page_e;
    typedef logic [7:0] vacr_byte_t;
endpackage

/* vacr_sync.sv */
// three-stage synchroniser with agreement of the last two stages
`timescale 1ns/1ps
module vacr_sync (
    // clock and reset
    input wire logic mclk_in,
    input wire logic rst_in,
    // asynchronous level and its clean copy
    input wire logic async_in,
    output logic sync_out
);
    logic s1_q; // first stage, read only by s2_q
    logic s2_q; // second stage
    logic s3_q; // third stage

    // shift chain; output moves only once stages two and three agree
    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            s1_q <= 1'b0;
            s2_q <= 1'b0;
            s3_q <= 1'b0;
            sync_out <= 1'b0;
        end else begin
            s1_q <= async_in;
            s2_q <= s1_q;
            s3_q <= s2_q;
            if (s2_q == s3_q) begin
                sync_out <= s3_q;
            end
        end
    end
endmodule

/* vacr_span_timer.sv */
// counts a clock span given in 50 ns units and pulses when it ends
`timescale 1ns/1ps
`include "vacr_cfg.svh"
module vacr_span_timer #(
    parameter int UNIT_CYC = `VACR_CYC_PER_UNIT
) (
    // clock and reset
    input wire logic mclk_in,
    input wire logic rst_in,
    // start strobe and span length
    input wire logic start_in,
    input wire logic [7:0] span_in,
    // status
    output logic busy_out,
    output logic done_out
);
    logic [7:0] units_q; // units still to run
    logic [7:0] cyc_q; // cycles within the current unit

    // load on start, then count unit by unit down to zero
    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            units_q <= 8'h00;
            cyc_q <= 8'h00;
            busy_out <= 1'b0;
            done_out <= 1'b0;
        end else begin
            done_out <= 1'b0;
            if (start_in) begin
                // a zero span still takes one unit, so no glitch-short pulse
                units_q <= (span_in == 8'h00) ? 8'h01 : span_in;
                cyc_q <= 8'(UNIT_CYC - 1);
                busy_out <= 1'b1;
            end else if (busy_out) begin
                if (cyc_q != 8'h00) begin
                    cyc_q <= cyc_q - 8'h01;
                end else if (units_q == 8'h01) begin
                    busy_out <= 1'b0;
                    done_out <= 1'b1;
                end else begin
                    units_q <= units_q - 8'h01;
                    cyc_q <= 8'(UNIT_CYC - 1);
                end
            end
        end
    end
endmodule

/* vacr_regs.sv */
// configuration and status register bank of the video/audio deserializer
//
// How it works
// [R1] read-only error tally saturating at 255
// [R2] host reads tally only after self test
// [R3] tally clears on power-down or new run
// [R4] master clock high span in 50 ns
// [R5] master clock low span in 50 ns
// [R6] low span doubles as slave data setup
// [R7] bit 7 blocks forward-channel loading
// [R8] bit 3 routes aux audio to gpio
// [R9] bit 2 disables all audio outputs
// [R10] bit 0 selects surround audio transport
// [R11] surround only with data-island, repeater override
// [R12] bit 7 selects sync or pixel-valid timing
// [R13] bits 6..4 set sync polarities
// [R14] bits 3,2 enable dither stages
// [R15] bits 1,0 disable fine dither stages
// [R16] bits 7:6 select balance page
// [R17] bit 5 enables white balance
// [R18] bit 4 enables table reload
// [R19] bit 7 enables audio pll override
// [R20] bit 6 turns audio pll off
// [R21] bit 0 picks audio strobe edge
// [R22] reserved bits read zero, ignore writes
`timescale 1ns/1ps
`include "vacr_cfg.svh"
module vacr_regs
    import vacr_pkg::*;
(
    // clock and reset
    input wire logic mclk_in,
    input wire logic rst_in,
    // device pins and pads, asynchronous to mclk_in
    input wire logic power_down_input_n_in,
    input wire logic self_test_run_in,
    // local register port from the serial control slave
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    input wire logic [7:0] reg_addr_in,
    input wire logic [7:0] reg_wdata_in,
    output logic [7:0] reg_rdata_out,
    output logic reg_rvalid_out,
    // forward-channel load of the path control register
    input wire logic fc_load_in,
    input wire logic [7:0] fc_data_in,
    // self-test error events, same clock
    input wire logic test_error_in,
    // repeater in-band surround detection
    input wire logic repeater_in,
    input wire logic inband_surround_in,
    input wire logic inband_valid_in,
    // data-island transport in use
    input wire logic data_island_in,
    // slave setup and master clock phase requests
    input wire logic slave_setup_start_in,
    input wire logic master_high_start_in,
    input wire logic master_low_start_in,
    output logic slave_setup_done_out,
    output logic master_phase_done_out,
    // audio controls
    output logic aux_audio_route_out,
    output logic audio_off_out,
    output logic surround_out,
    output logic pll_override_out,
    output logic pll_off_out,
    output logic edge_rise_out,
    // video timing and dither controls
    output logic sync_mode_out,
    output logic line_sync_low_out,
    output logic frame_sync_low_out,
    output logic pixel_valid_low_out,
    output logic dither_stage_two_out,
    output logic dither_stage_one_out,
    output logic fine_dither_stage_two_out,
    output logic fine_dither_stage_one_out,
    // white-balance controls
    output logic [1:0] balance_page_out,
    output logic balance_en_out,
    output logic lut_reload_out,
    // tally valid once the run is over
    output logic tally_valid_out
);
    vacr_byte_t tally_q; // error tally
    vacr_byte_t high_span_q; // master clock high span
    vacr_byte_t low_span_q; // master clock low span
    vacr_byte_t path_q; // path control second
    vacr_byte_t dither_q; // dither and timing control
    vacr_byte_t balance_q; // color balance control
    vacr_byte_t audio_q; // audio serial control
    logic pd_n_s; // synchronised power-down, low means down
    logic run_s; // synchronised self-test run
    logic run_prev_q; // run level one cycle back
    logic run_start; // rising edge of run
    logic bank_clr; // whole bank back to reset values
    logic setup_busy; // slave setup timer busy
    logic high_busy; // master high timer busy
    logic setup_done; // slave setup ended
    logic high_done; // master high phase ended
    logic low_done; // master low phase ended
    logic surr_eff; // surround bit after repeater override
    vacr_page_e page; // decoded balance page

    // pins from outside the clock domain
    vacr_sync u_pd_sync (
        .mclk_in(mclk_in),
        .rst_in(rst_in),
        .async_in(power_down_input_n_in),
        .sync_out(pd_n_s)
    );
    vacr_sync u_run_sync (
        .mclk_in(mclk_in),
        .rst_in(rst_in),
        .async_in(self_test_run_in),
        .sync_out(run_s)
    );

    // edge of the run level, taken from the clean copy only
    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            run_prev_q <= 1'b0;
        end else begin
            run_prev_q <= run_s;
        end
    end
    assign run_start = run_s & ~run_prev_q;
    // power-down clears the bank like a reset; the sync resets low,
    // so the bank is held cleared until the pin is seen high
    assign bank_clr = ~pd_n_s;

    // [R3] tally clear on power-down/new run
    // [R1] saturating tally
    always_ff @(posedge mclk_in) begin
        if (rst_in || bank_clr || run_start) begin
            tally_q <= `VACR_RST_ERR_TALLY;
        end else if (run_s && test_error_in &&
                     tally_q != `VACR_TALLY_MAX) begin
            tally_q <= tally_q + 8'h01;
        end
    end

    // [R4] high span register
    // [R5] low span register
    always_ff @(posedge mclk_in) begin
        if (rst_in || bank_clr) begin
            high_span_q <= `VACR_RST_HIGH_SPAN;
            low_span_q <= `VACR_RST_LOW_SPAN;
        end else if (reg_wr_in) begin
            if (reg_addr_in == `VACR_ADDR_HIGH_SPAN) begin
                high_span_q <= reg_wdata_in;
            end
            if (reg_addr_in == `VACR_ADDR_LOW_SPAN) begin
                low_span_q <= reg_wdata_in;
            end
        end
    end

    // path control; a local write wins over a forward-channel load
    always_ff @(posedge mclk_in) begin
        if (rst_in || bank_clr) begin
            path_q <= `VACR_RST_ZERO;
        end else if (reg_wr_in && reg_addr_in == `VACR_ADDR_PATH_CTL2) begin
            // [R22] reserved bits masked
            path_q <= reg_wdata_in & `VACR_MASK_PATH_CTL2;
        // [R7] forward-channel block
        end else if (fc_load_in && !path_q[`VACR_BIT_FC_BLOCK]) begin
            path_q <= fc_data_in & `VACR_MASK_PATH_CTL2;
        end
    end

    // dither, balance and audio control writes
    always_ff @(posedge mclk_in) begin
        if (rst_in || bank_clr) begin
            dither_q <= `VACR_RST_ZERO;
            balance_q <= `VACR_RST_ZERO;
            audio_q <= `VACR_RST_ZERO;
        end else if (reg_wr_in) begin
            if (reg_addr_in == `VACR_ADDR_DITHER_CTL) begin
                dither_q <= reg_wdata_in;
            end
            // [R22] reserved bits masked
            if (reg_addr_in == `VACR_ADDR_BALANCE_CTL) begin
                balance_q <= reg_wdata_in & `VACR_MASK_BALANCE_CTL;
            end
            if (reg_addr_in == `VACR_ADDR_AUDIO_CTL) begin
                audio_q <= reg_wdata_in & `VACR_MASK_AUDIO_CTL;
            end
        end
    end

    // read port; one cycle after the strobe, unmapped reads zero
    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            reg_rdata_out <= 8'h00;
            reg_rvalid_out <= 1'b0;
        end else begin
            reg_rvalid_out <= reg_rd_in;
            if (reg_rd_in) begin
                case (reg_addr_in)
                    // [R1] tally is read-only
                    `VACR_ADDR_ERR_TALLY: reg_rdata_out <= tally_q;
                    `VACR_ADDR_HIGH_SPAN: reg_rdata_out <= high_span_q;
                    `VACR_ADDR_LOW_SPAN: reg_rdata_out <= low_span_q;
                    `VACR_ADDR_PATH_CTL2: reg_rdata_out <= path_q;
                    `VACR_ADDR_DITHER_CTL: reg_rdata_out <= dither_q;
                    `VACR_ADDR_BALANCE_CTL: reg_rdata_out <= balance_q;
                    `VACR_ADDR_AUDIO_CTL: reg_rdata_out <= audio_q;
                    default: reg_rdata_out <= 8'h00;
                endcase
            end
        end
    end

    // [R6] slave setup uses low span
    vacr_span_timer u_setup (
        .mclk_in(mclk_in),
        .rst_in(rst_in),
        .start_in(slave_setup_start_in),
        .span_in(low_span_q),
        .busy_out(setup_busy),
        .done_out(setup_done)
    );
    // [R4] master high phase timing
    vacr_span_timer u_high (
        .mclk_in(mclk_in),
        .rst_in(rst_in),
        .start_in(master_high_start_in),
        .span_in(high_span_q),
        .busy_out(high_busy),
        .done_out(high_done)
    );
    // [R5] master low phase timing
    vacr_span_timer u_low (
        .mclk_in(mclk_in),
        .rst_in(rst_in),
        .start_in(master_low_start_in),
        .span_in(low_span_q),
        .busy_out(),
        .done_out(low_done)
    );

    // [R11] repeater override, data-island only
    always_comb begin
        surr_eff = path_q[`VACR_BIT_SURROUND];
        if (repeater_in && inband_valid_in) begin
            surr_eff = inband_surround_in;
        end
        if (!data_island_in) begin
            surr_eff = 1'b0;
        end
    end
    assign page = vacr_page_e'(balance_q[7:6]);

    // registered control outputs
    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            slave_setup_done_out <= 1'b0;
            master_phase_done_out <= 1'b0;
            aux_audio_route_out <= 1'b0;
            audio_off_out <= 1'b0;
            surround_out <= 1'b0;
            pll_override_out <= 1'b0;
            pll_off_out <= 1'b0;
            edge_rise_out <= 1'b0;
            sync_mode_out <= 1'b0;
            line_sync_low_out <= 1'b0;
            frame_sync_low_out <= 1'b0;
            pixel_valid_low_out <= 1'b0;
            dither_stage_two_out <= 1'b0;
            dither_stage_one_out <= 1'b0;
            fine_dither_stage_two_out <= 1'b1;
            fine_dither_stage_one_out <= 1'b1;
            balance_page_out <= 2'h0;
            balance_en_out <= 1'b0;
            lut_reload_out <= 1'b0;
            tally_valid_out <= 1'b0;
        end else begin
            slave_setup_done_out <= setup_done;
            master_phase_done_out <= high_done | low_done;
            // [R8] aux audio routing
            aux_audio_route_out <= path_q[`VACR_BIT_AUX_AUDIO];
            // [R9] all audio outputs off
            audio_off_out <= path_q[`VACR_BIT_AUDIO_OFF];
            // [R10] surround transport select
            surround_out <= surr_eff;
            // [R19] pll override
            pll_override_out <= audio_q[`VACR_BIT_PLL_OVR];
            // [R20] pll off
            pll_off_out <= audio_q[`VACR_BIT_PLL_OFF];
            // [R21] strobe edge
            edge_rise_out <= audio_q[`VACR_BIT_EDGE_RISE];
            // [R12] timing mode
            sync_mode_out <= dither_q[`VACR_BIT_SYNC_MODE];
            // [R13] sync polarities
            line_sync_low_out <= dither_q[`VACR_BIT_LSYNC_POL];
            frame_sync_low_out <= dither_q[`VACR_BIT_FSYNC_POL];
            pixel_valid_low_out <= dither_q[`VACR_BIT_PVALID_POL];
            // [R14] dither stage enables
            dither_stage_two_out <= dither_q[`VACR_BIT_DITH_TWO];
            dither_stage_one_out <= dither_q[`VACR_BIT_DITH_ONE];
            // [R15] fine stages, inverted sense
            fine_dither_stage_two_out <= ~dither_q[`VACR_BIT_FINE_TWO];
            fine_dither_stage_one_out <= ~dither_q[`VACR_BIT_FINE_ONE];
            // [R16] page select
            balance_page_out <= page;
            // [R17] balance enable
            balance_en_out <= balance_q[`VACR_BIT_BAL_EN];
            // [R18] table reload enable
            lut_reload_out <= balance_q[`VACR_BIT_LUT_RELOAD];
            // [R2] valid only when run low
            tally_valid_out <= ~run_s;
        end
    end

    // saturation: tally never wraps from 255
    tally_sat_a: assert property (@(posedge mclk_in) disable iff (rst_in)
        tally_q == `VACR_TALLY_MAX && !bank_clr && !run_start
        |=> tally_q == `VACR_TALLY_MAX) // [R1]
        else $error("tally wrapped past maximum");
    // clears follow a new run or power-down
    tally_clear_a: assert property (@(posedge mclk_in) disable iff (rst_in)
        (run_start || bank_clr) |=> tally_q == 8'h00) // [R3]
        else $error("tally not cleared");
    // blocked forward load leaves path untouched
    fc_block_a: assert property (@(posedge mclk_in) disable iff (rst_in)
        fc_load_in && path_q[7] && !reg_wr_in && !bank_clr
        |=> $stable(path_q)) // [R7]
        else $error("forward load overwrote blocked register");
    // reserved bits of path stay zero
    path_resv_a: assert property (@(posedge mclk_in) disable iff (rst_in)
        (path_q & 8'h72) == 8'h00) // [R22]
        else $error("reserved path bits set");
    // fine dither stage one output inverted from bit 0
    fine_sense_a: assert property (@(posedge mclk_in) disable iff (rst_in)
        ##1 fine_dither_stage_one_out == ~$past(dither_q[0])) // [R15]
        else $error("fine dither sense wrong");
    // setup span is one unit when low span is 0 or 1
    setup_span_a: assert property (@(posedge mclk_in) disable iff (rst_in)
        slave_setup_start_in && low_span_q <= 8'h01 && !high_busy
        |=> setup_busy [*2] ##1 !setup_busy) // [R6]
        else $error("setup span length wrong");
    // surround cleared without data island
    surr_island_a: assert property (@(posedge mclk_in) disable iff (rst_in)
        !data_island_in |=> !surround_out) // [R11]
        else $error("surround without data island");
    // pll off follows audio bit 6
    pll_off_a: assert property (@(posedge mclk_in) disable iff (rst_in)
        reg_wr_in && reg_addr_in == 8'h2b && !bank_clr
        |=> ##1 pll_off_out == $past(reg_wdata_in[6], 2)) // [R20]
        else $error("pll off not following write");
endmodule

/* vacr_host_model.sv */
// host-side model that issues register writes and reads to the bank
`timescale 1ns/1ps
module vacr_host_model
    import vacr_pkg::*;
(
    // clock
    input wire logic mclk_in,
    // read answer from the bank
    input wire logic [7:0] reg_rdata_in,
    input wire logic reg_rvalid_in,
    // request lines
    output logic reg_wr_out,
    output logic reg_rd_out,
    output logic [7:0] reg_addr_out,
    output logic [7:0] reg_wdata_out
);
    // idle request lines from time zero
    initial begin
        reg_wr_out = 1'b0;
        reg_rd_out = 1'b0;
        reg_addr_out = 8'h00;
        reg_wdata_out = 8'h00;
    end

    // one-cycle write strobe, taken at the rising edge inside it
    task automatic wr(input vacr_byte_t a, input vacr_byte_t d);
        @(negedge mclk_in);
        reg_addr_out = a;
        reg_wdata_out = d;
        reg_wr_out = 1'b1;
        @(negedge mclk_in);
        reg_wr_out = 1'b0;
        // flip data so a stale byte cannot pass as held
        reg_wdata_out = ~d;
    endtask

    // one-cycle read strobe; the answer pulse stands in the next cycle
    task automatic rd(input vacr_byte_t a, output vacr_byte_t d);
        @(negedge mclk_in);
        reg_addr_out = a;
        reg_rd_out = 1'b1;
        @(negedge mclk_in);
        reg_rd_out = 1'b0;
        // a late or missing answer leaves the byte unknown
        d = (reg_rvalid_in === 1'b1) ? reg_rdata_in : 8'hxx;
    endtask
endmodule

/* vacr_regs_tb.sv */
// self-checking bench for the configuration register bank
`timescale 1ns/1ps
module vacr_regs_tb
    import vacr_pkg::*;
;
    // design-side signals
    logic mclk_in = 1'b0, rst_in, power_down_input_n_in, self_test_run_in;
    logic reg_wr_in, reg_rd_in, reg_rvalid_out, fc_load_in, test_error_in;
    logic [7:0] reg_addr_in, reg_wdata_in, reg_rdata_out, fc_data_in;
    logic repeater_in, inband_surround_in, inband_valid_in, data_island_in;
    logic slave_setup_start_in, master_high_start_in, master_low_start_in;
    logic slave_setup_done_out, master_phase_done_out, aux_audio_route_out;
    logic audio_off_out, surround_out, pll_override_out, pll_off_out;
    logic edge_rise_out, sync_mode_out, line_sync_low_out;
    logic frame_sync_low_out, pixel_valid_low_out, dither_stage_two_out;
    logic dither_stage_one_out, fine_dither_stage_two_out;
    logic fine_dither_stage_one_out, balance_en_out, lut_reload_out;
    logic tally_valid_out;
    logic [1:0] balance_page_out;
    // shadow of expected contents, counters, seed
    vacr_byte_t sh [8'h25:8'h2b];
    int error_cnt = 0, check_count = 0, cyc = 0;
    int seed;

    vacr_regs i_vacr_regs (
        .mclk_in, .rst_in, .power_down_input_n_in, .self_test_run_in,
        .reg_wr_in, .reg_rd_in, .reg_addr_in, .reg_wdata_in,
        .reg_rdata_out, .reg_rvalid_out, .fc_load_in, .fc_data_in,
        .test_error_in, .repeater_in, .inband_surround_in,
        .inband_valid_in, .data_island_in, .slave_setup_start_in,
        .master_high_start_in, .master_low_start_in,
        .slave_setup_done_out, .master_phase_done_out,
        .aux_audio_route_out, .audio_off_out, .surround_out,
        .pll_override_out, .pll_off_out, .edge_rise_out, .sync_mode_out,
        .line_sync_low_out, .frame_sync_low_out, .pixel_valid_low_out,
        .dither_stage_two_out, .dither_stage_one_out,
        .fine_dither_stage_two_out, .fine_dither_stage_one_out,
        .balance_page_out, .balance_en_out, .lut_reload_out,
        .tally_valid_out
    );
    vacr_host_model host (
        .mclk_in, .reg_rdata_in(reg_rdata_out),
        .reg_rvalid_in(reg_rvalid_out), .reg_wr_out(reg_wr_in),
        .reg_rd_out(reg_rd_in), .reg_addr_out(reg_addr_in),
        .reg_wdata_out(reg_wdata_in)
    );

    // 40 MHz clock
    initial forever #12.5 mclk_in = ~mclk_in;

    // hang guard, far above the under one thousand cycles needed
    always @(posedge mclk_in) begin
        cyc++;
        if (cyc == 30000) begin
            error_cnt++;
            print_verdict();
        end
    end

    task automatic print_verdict();
        if (error_cnt == 0 && check_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic chk(input vacr_byte_t got, input vacr_byte_t exp);
        check_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    endtask

    // writable bits per address; none if unmapped or read-only
    function automatic vacr_byte_t wmask(input vacr_byte_t a);
        case (a)
            8'h26, 8'h27, 8'h29: return 8'hff;
            8'h28: return 8'h8d;
            8'h2a: return 8'hf0;
            8'h2b: return 8'hc1;
            default: return 8'h00;
        endcase
    endfunction

    task automatic reset_shadow();
        foreach (sh[a]) sh[a] = 8'h00;
        sh[8'h26] = 8'h83;
        sh[8'h27] = 8'h84;
    endtask

    task automatic wreg(input vacr_byte_t a, input vacr_byte_t d);
        host.wr(a, d);
        if (a >= 8'h25 && a <= 8'h2b) begin
            sh[a] = (sh[a] & ~wmask(a)) | (d & wmask(a));
        end
    endtask

    task automatic rdchk(input vacr_byte_t a);
        vacr_byte_t d;
        host.rd(a, d);
        chk(d, (a >= 8'h25 && a <= 8'h2b) ? sh[a] : 8'h00);
    endtask

    // control levels against the shadow, once settled
    task automatic chk_outs();
        repeat (2) @(negedge mclk_in);
        chk({4'h0, aux_audio_route_out, audio_off_out, 1'b0, surround_out},
            {4'h0, sh[8'h28][3:2], 1'b0, sh[8'h28][0] & data_island_in});
        chk({sync_mode_out, line_sync_low_out, frame_sync_low_out,
             pixel_valid_low_out, dither_stage_two_out, dither_stage_one_out,
             ~fine_dither_stage_two_out, ~fine_dither_stage_one_out},
            sh[8'h29]);
        chk({balance_page_out, balance_en_out, lut_reload_out, 4'h0},
            sh[8'h2a]);
        chk({pll_override_out, pll_off_out, 5'h00, edge_rise_out},
            sh[8'h2b]);
    endtask

    task automatic pulse_err();
        @(negedge mclk_in);
        test_error_in = 1'b1;
        @(negedge mclk_in);
        test_error_in = 1'b0;
    endtask

    task automatic fc_load(input vacr_byte_t d);
        @(negedge mclk_in);
        fc_load_in = 1'b1;
        fc_data_in = d;
        @(negedge mclk_in);
        fc_load_in = 1'b0;
        fc_data_in = ~d;
    endtask

    // ends a run and waits, bounded, until the tally may be read
    task automatic end_run();
        int n;
        self_test_run_in = 1'b0;
        for (n = 0; n < 20 && tally_valid_out !== 1'b1; n++) begin
            @(negedge mclk_in);
        end
        chk({7'h00, tally_valid_out}, 8'h01);
    endtask

    // span of 50 ns units is two cycles each; zero counts as one unit
    task automatic span_run(input int sel, input int span);
        int n;
        int e;
        e = 2 * ((span == 0) ? 1 : span);
        @(negedge mclk_in);
        master_high_start_in = (sel == 0);
        master_low_start_in = (sel == 1);
        slave_setup_start_in = (sel == 2);
        @(negedge mclk_in);
        {master_high_start_in, master_low_start_in} = 2'b00;
        slave_setup_start_in = 1'b0;
        n = 1;
        while (((sel == 2) ? slave_setup_done_out : master_phase_done_out)
               !== 1'b1 && n < 600) begin
            @(negedge mclk_in);
            n++;
        end
        // allows the fixed start and done latency, not a whole unit more
        chk({7'h00, (n >= e && n <= e + 3)}, 8'h01);
    endtask

    initial begin
        int i;
        int a;
        seed = 32'he892;
        {rst_in, power_down_input_n_in, data_island_in} = 3'b111;
        {self_test_run_in, fc_load_in, test_error_in} = 3'b000;
        {repeater_in, inband_surround_in, inband_valid_in} = 3'b000;
        {slave_setup_start_in, master_high_start_in} = 2'b00;
        master_low_start_in = 1'b0;
        fc_data_in = 8'h00;
        repeat (8) @(negedge mclk_in);
        rst_in = 1'b0;
        repeat (8) @(negedge mclk_in);
        reset_shadow();
        // reset values, unmapped neighbours included
        for (a = 8'h24; a <= 8'h2c; a++) rdchk(a[7:0]);
        chk_outs();
        // all ones everywhere, read-only and unmapped too
        for (a = 8'h24; a <= 8'h2c; a++) begin
            wreg(a[7:0], 8'hff);
            rdchk(a[7:0]);
        end
        // random traffic with random in-band inputs left unused
        for (i = 0; i < 24; i++) begin
            a = 8'h25 + ($random(seed) & 7);
            data_island_in = $random(seed);
            {inband_surround_in, inband_valid_in} = $random(seed);
            wreg(a[7:0], $random(seed));
            rdchk(a[7:0]);
            chk_outs();
        end
        {inband_surround_in, inband_valid_in, data_island_in} = 3'b001;
        // forward load passes unless bit 7 blocks it
        wreg(8'h28, 8'h00);
        fc_load(8'h0d);
        sh[8'h28] = 8'h0d;
        rdchk(8'h28);
        wreg(8'h28, 8'h84);
        fc_load(8'h09);
        rdchk(8'h28);
        // surround needs data-island; repeater detection overrides
        wreg(8'h28, 8'h01);
        data_island_in = 1'b0;
        repeat (3) @(negedge mclk_in);
        chk({7'h00, surround_out}, 8'h00);
        {data_island_in, repeater_in, inband_valid_in} = 3'b111;
        repeat (3) @(negedge mclk_in);
        chk({7'h00, surround_out}, 8'h00);
        wreg(8'h28, 8'h00);
        inband_surround_in = 1'b1;
        repeat (3) @(negedge mclk_in);
        chk({7'h00, surround_out}, 8'h01);
        {repeater_in, inband_valid_in, inband_surround_in} = 3'b000;
        // tally counts, ignores writes, clears on a new run, saturates
        self_test_run_in = 1'b1;
        repeat (8) @(negedge mclk_in);
        for (i = 0; i < 5; i++) pulse_err();
        end_run();
        sh[8'h25] = 8'h05;
        rdchk(8'h25);
        wreg(8'h25, 8'haa);
        rdchk(8'h25);
        self_test_run_in = 1'b1;
        repeat (8) @(negedge mclk_in);
        sh[8'h25] = 8'h00;
        rdchk(8'h25);
        for (i = 0; i < 260; i++) pulse_err();
        end_run();
        sh[8'h25] = 8'hff;
        rdchk(8'h25);
        // power-down clears the tally and the high span
        wreg(8'h26, 8'h11);
        power_down_input_n_in = 1'b0;
        repeat (8) @(negedge mclk_in);
        power_down_input_n_in = 1'b1;
        repeat (8) @(negedge mclk_in);
        reset_shadow();
        rdchk(8'h25);
        rdchk(8'h26);
        // span timers, high at 3 units, low and setup both at 6, zero as the boundary
        wreg(8'h26, 8'h03);
        wreg(8'h27, 8'h06);
        span_run(0, 3);
        span_run(1, 6);
        span_run(2, 6);
        wreg(8'h27, 8'h00);
        span_run(2, 0);
        print_verdict();
    end
endmodule
